// ### include/eeprom_host_pkg.sv
// Package of constants and carrier types for the parallel EEPROM page-write host
package eeprom_host_pkg;
    localparam int CLK_MHZ = 125;
    localparam int ADDR_W = 17;
    localparam int PAGE_BYTES = 128;
    localparam int OFFSET_W = 7;
    // Timing figures in their own units
    localparam int STROBE_NS = 250;
    localparam int SETUP_NS = 100;
    localparam int HOLD_NS = 24;
    localparam int LOAD_WINDOW_US = 30;
    localparam int IDLE_US = 100;
    localparam int HOLD_AFTER_MS = 10;
    localparam int WRITE_CYCLE_MS = 15;
    localparam int READ_NS = 300;
    // Derived cycle counts (least times round up)
    localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int READ_CYC = (READ_NS * CLK_MHZ + 999) / 1000;
    localparam int LOAD_WINDOW_CYC = LOAD_WINDOW_US * CLK_MHZ;
    localparam int IDLE_CYC = IDLE_US * CLK_MHZ;
    localparam int HOLD_AFTER_CYC = HOLD_AFTER_MS * 1000 * CLK_MHZ;
    localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_MS * 1000 * CLK_MHZ;
    localparam int CNT_W = 22;
    // Unlock and cancel sequence addresses and data
    localparam logic [ADDR_W-1:0] SEQ_ADDR_A = 17'h05555;
    localparam logic [ADDR_W-1:0] SEQ_ADDR_B = 17'h02AAA;
    localparam logic [7:0] SEQ_DATA_AA = 8'hAA;
    localparam logic [7:0] SEQ_DATA_55 = 8'h55;
    localparam logic [7:0] SEQ_DATA_80 = 8'h80;
    localparam logic [7:0] SEQ_DATA_A0 = 8'hA0;
    localparam logic [7:0] SEQ_DATA_20 = 8'h20;
    localparam int POLL_BIT = 7;

    // Pin bundle toward the EEPROM
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] dq_out;
        logic dq_oe;
        logic chip_sel_n;
        logic out_en_n;
        logic wr_strobe_n;
        logic protect_hold_n;
    } pins_s;

    // User request: one byte of a page, with a flag on the last byte
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
        logic last;
    } byte_req_s;
endpackage

// ### rtl/eeprom_strobe.sv
// One byte strobe cycle on the EEPROM pins: setup, low pulse, hold
`timescale 1ns/1ps
module eeprom_strobe
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic is_read,
    output logic strobe_low,
    output logic sample,
    output logic done
);
    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_LOW, ST_HOLD} stb_e;
    typedef struct packed {
        stb_e st;
        logic [7:0] cnt;
    } stb_s;
    stb_s s_reg;
    stb_s s_next;

    // Sequence the phases of one strobe
    always_comb
    begin
        s_next = s_reg;
        sample = 1'b0;
        done = 1'b0;
        case (s_reg.st)
            ST_IDLE:
            begin
                if (start)
                begin
                    s_next.st = ST_SETUP;
                    s_next.cnt = 8'(eeprom_host_pkg::SETUP_CYC);
                end
            end
            ST_SETUP:
            begin
                if (s_reg.cnt <= 8'h01)
                begin
                    s_next.st = ST_LOW;
                    s_next.cnt = is_read ? 8'(eeprom_host_pkg::READ_CYC) : 8'(eeprom_host_pkg::STROBE_CYC);
                end
                else
                    s_next.cnt = s_reg.cnt - 8'h01;
            end
            ST_LOW:
            begin
                if (s_reg.cnt <= 8'h01)
                begin
                    sample = is_read; // Read data taken at end of pulse
                    s_next.st = ST_HOLD;
                    s_next.cnt = 8'(eeprom_host_pkg::HOLD_CYC);
                end
                else
                    s_next.cnt = s_reg.cnt - 8'h01;
            end
            ST_HOLD:
            begin
                if (s_reg.cnt <= 8'h01)
                begin
                    done = 1'b1;
                    s_next.st = ST_IDLE;
                end
                else
                    s_next.cnt = s_reg.cnt - 8'h01;
            end
            default: s_next.st = ST_IDLE;
        endcase
    end

    assign strobe_low = (s_reg.st == ST_LOW);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            s_reg <= '{st: ST_IDLE, cnt: 8'h00};
        else
            s_reg <= s_next;
    end

    // Strobe pulse lasts well over the glitch filter width
    AST_PULSE_WIDE: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(strobe_low) |-> strobe_low [*3]) else $error("strobe pulse too short");
endmodule // eeprom_strobe

// ### rtl/eeprom_page_host.sv
// Host controller that loads pages into a parallel EEPROM and waits for completion
`timescale 1ns/1ps
module eeprom_page_host
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic power_good,
    input wire logic protect_mode,
    input wire logic cancel_req,
    input wire logic req_valid,
    input wire eeprom_host_pkg::byte_req_s req,
    output logic req_ready,
    output eeprom_host_pkg::pins_s pins,
    input wire logic [7:0] dq_in,
    input wire logic ready_busy_n,
    output logic busy,
    output logic done_pulse,
    output logic timeout_pulse
);
    localparam int OFFSET_HI = eeprom_host_pkg::OFFSET_W;
    typedef enum logic [2:0] {S_IDLE, S_PRE, S_WAIT_BYTE, S_LOAD, S_IDLE_WAIT, S_POLL, S_DONE} st_e;
    typedef struct packed {
        st_e st;
        logic [2:0] pre_idx;
        logic cancel;
        logic [eeprom_host_pkg::ADDR_W-1:0] addr;
        logic [eeprom_host_pkg::ADDR_W-OFFSET_HI-1:0] page;
        logic [7:0] data;
        logic last;
        logic poll_bit;
        logic [eeprom_host_pkg::CNT_W-1:0] win_cnt;
        logic [eeprom_host_pkg::CNT_W-1:0] wc_cnt;
        logic [7:0] byte_cnt;
        logic started;
        logic pg_en;
        logic done_p;
        logic to_p;
    } host_s;
    localparam logic [eeprom_host_pkg::CNT_W-1:0] CNT_ONE = 22'h000001;
    host_s s_reg;
    host_s s_next;
    logic stb_start;
    logic stb_read;
    logic stb_low;
    logic stb_sample;
    logic stb_done;

    eeprom_strobe u_strobe
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .start(stb_start),
        .is_read(stb_read),
        .strobe_low(stb_low),
        .sample(stb_sample),
        .done(stb_done)
    );

    // Prefix byte address and data for unlock and cancel sequences
    function automatic logic [eeprom_host_pkg::ADDR_W+7:0] seq_word(input logic [2:0] idx);
        case (idx)
            3'h0: seq_word = {eeprom_host_pkg::SEQ_ADDR_A, eeprom_host_pkg::SEQ_DATA_AA};
            3'h1: seq_word = {eeprom_host_pkg::SEQ_ADDR_B, eeprom_host_pkg::SEQ_DATA_55};
            3'h3: seq_word = {eeprom_host_pkg::SEQ_ADDR_A, eeprom_host_pkg::SEQ_DATA_AA};
            3'h4: seq_word = {eeprom_host_pkg::SEQ_ADDR_B, eeprom_host_pkg::SEQ_DATA_55};
            default: seq_word = {eeprom_host_pkg::SEQ_ADDR_A, eeprom_host_pkg::SEQ_DATA_80};
        endcase
    endfunction

    logic [eeprom_host_pkg::ADDR_W+7:0] pre_word;
    logic [2:0] pre_len;
    always_comb
    begin
        pre_len = s_reg.cancel ? 3'h6 : 3'h3;
        if (s_reg.cancel && s_reg.pre_idx == 3'h5)
            pre_word = {eeprom_host_pkg::SEQ_ADDR_A, eeprom_host_pkg::SEQ_DATA_20};
        else if (!s_reg.cancel && s_reg.pre_idx == 3'h2)
            pre_word = {eeprom_host_pkg::SEQ_ADDR_A, eeprom_host_pkg::SEQ_DATA_A0};
        else
            pre_word = seq_word(s_reg.pre_idx);
    end

    // Main sequencer
    always_comb
    begin
        s_next = s_reg;
        s_next.done_p = 1'b0;
        s_next.to_p = 1'b0;
        stb_start = 1'b0;
        stb_read = 1'b0;
        req_ready = 1'b0;
        s_next.pg_en = power_good;
        if (s_reg.win_cnt != '0)
            s_next.win_cnt = s_reg.win_cnt - CNT_ONE;
        if (s_reg.wc_cnt != '0)
            s_next.wc_cnt = s_reg.wc_cnt - CNT_ONE;
        case (s_reg.st)
            S_IDLE:
            begin
                if (s_reg.pg_en && cancel_req)
                begin
                    s_next.cancel = 1'b1;
                    s_next.pre_idx = 3'h0;
                    s_next.st = S_PRE;
                end
                else if (s_reg.pg_en && req_valid)
                begin
                    s_next.cancel = 1'b0;
                    s_next.pre_idx = 3'h0;
                    s_next.page = req.addr[eeprom_host_pkg::ADDR_W-1:OFFSET_HI];
                    s_next.byte_cnt = 8'h00;
                    s_next.st = protect_mode ? S_PRE : S_WAIT_BYTE;
                end
            end
            S_PRE:
            begin
                if (!s_reg.started)
                begin
                    s_next.addr = pre_word[eeprom_host_pkg::ADDR_W+7:8];
                    s_next.data = pre_word[7:0];
                    stb_start = 1'b1;
                    s_next.started = 1'b1;
                end
                else if (stb_done)
                begin
                    s_next.started = 1'b0;
                    s_next.win_cnt = 22'(eeprom_host_pkg::LOAD_WINDOW_CYC);
                    if (s_reg.pre_idx == pre_len - 3'h1)
                    begin
                        s_next.st = s_reg.cancel ? S_IDLE_WAIT : S_WAIT_BYTE;
                        // Cancel ends with the full idle, strobes high
                        if (s_reg.cancel)
                            s_next.win_cnt = 22'(eeprom_host_pkg::IDLE_CYC);
                    end
                    else
                        s_next.pre_idx = s_reg.pre_idx + 3'h1;
                end
            end
            S_WAIT_BYTE:
            begin
                req_ready = 1'b1;
                if (req_valid)
                begin
                    // Upper lines held to the page, low lines from the request
                    s_next.addr = {s_reg.page, req.addr[OFFSET_HI-1:0]};
                    s_next.data = req.data;
                    s_next.last = req.last || (s_reg.byte_cnt == 8'(eeprom_host_pkg::PAGE_BYTES - 1));
                    s_next.st = S_LOAD;
                end
                else if (s_reg.byte_cnt != 8'h00 && s_reg.win_cnt == 22'(eeprom_host_pkg::SETUP_CYC * 4))
                begin
                    // Window nearly over: close the page rather than miss it
                    s_next.st = S_IDLE_WAIT;
                    s_next.win_cnt = 22'(eeprom_host_pkg::IDLE_CYC);
                end
            end
            S_LOAD:
            begin
                if (!s_reg.started)
                begin
                    stb_start = 1'b1;
                    s_next.started = 1'b1;
                end
                else if (stb_done)
                begin
                    s_next.started = 1'b0;
                    s_next.poll_bit = s_reg.data[eeprom_host_pkg::POLL_BIT];
                    s_next.byte_cnt = s_reg.byte_cnt + 8'h01;
                    if (s_reg.last)
                    begin
                        s_next.st = S_IDLE_WAIT;
                        s_next.win_cnt = 22'(eeprom_host_pkg::IDLE_CYC);
                    end
                    else
                    begin
                        s_next.st = S_WAIT_BYTE;
                        s_next.win_cnt = 22'(eeprom_host_pkg::LOAD_WINDOW_CYC);
                    end
                end
            end
            S_IDLE_WAIT:
            begin
                // Strobes stay high so the device starts programming itself
                if (s_reg.win_cnt <= CNT_ONE)
                begin
                    s_next.st = S_POLL;
                    s_next.wc_cnt = 22'(eeprom_host_pkg::WRITE_CYCLE_CYC);
                end
            end
            S_POLL:
            begin
                if (!s_reg.started)
                begin
                    stb_start = 1'b1;
                    s_next.started = 1'b1;
                end
                else if (stb_done)
                    s_next.started = 1'b0;
                if (stb_sample && (s_reg.cancel || dq_in[eeprom_host_pkg::POLL_BIT] == s_reg.poll_bit) && ready_busy_n)
                begin
                    s_next.last = 1'b0; // Clean finish
                    s_next.st = S_DONE;
                end
                else if (s_reg.wc_cnt == CNT_ONE)
                begin
                    s_next.last = 1'b1; // Marks a timeout until the read ends
                    s_next.st = S_DONE;
                end
                stb_read = 1'b1;
            end
            S_DONE:
            begin
                if (!s_reg.started)
                begin
                    s_next.done_p = !s_reg.last;
                    s_next.to_p = s_reg.last;
                    s_next.st = S_IDLE;
                end
                else if (stb_done)
                    s_next.started = 1'b0;
                stb_read = 1'b1;
            end
            default: s_next.st = S_IDLE;
        endcase
        if (!power_good)
        begin
            // Supply ramping: abandon everything, hold device protected
            s_next.st = S_IDLE;
            s_next.started = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            s_reg <= '{st: S_IDLE, default: '0};
        else
            s_reg <= s_next;
    end

    // Pin drive: select falls and rises with the write strobe on writes, with output enable on reads
    always_comb
    begin
        pins.addr = s_reg.addr;
        pins.dq_out = s_reg.data;
        pins.dq_oe = (s_reg.st == S_PRE || s_reg.st == S_LOAD) && s_reg.started;
        // Strobes cut with protect/hold so no access outlives it
        pins.chip_sel_n = !(stb_low && s_reg.pg_en);
        pins.wr_strobe_n = !(stb_low && !stb_read && s_reg.pg_en);
        pins.out_en_n = !(stb_low && stb_read && s_reg.pg_en);
        pins.protect_hold_n = s_reg.pg_en && !sys_rst;
    end
    assign busy = (s_reg.st != S_IDLE);
    assign done_pulse = s_reg.done_p;
    assign timeout_pulse = s_reg.to_p;

    sequence LOAD_END;
        (s_reg.st == S_LOAD) && stb_done && s_reg.last;
    endsequence
    AST_IDLE_AFTER_LAST: assert property (@(posedge clk) disable iff (sys_rst)
        LOAD_END |=> (s_reg.st == S_IDLE_WAIT) && pins.chip_sel_n) else $error("no idle after last byte");
    AST_HOLD_DURING_ACCESS: assert property (@(posedge clk) disable iff (sys_rst)
        !pins.chip_sel_n |-> pins.protect_hold_n) else $error("access without protect hold high");
    AST_POWER_LOW: assert property (@(posedge clk) disable iff (sys_rst)
        !power_good |=> !pins.protect_hold_n) else $error("protect hold not low on power ramp");
    AST_WINDOW_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
        (s_reg.st == S_LOAD) && stb_done && !s_reg.last |=> s_reg.win_cnt == 22'(eeprom_host_pkg::LOAD_WINDOW_CYC))
        else $error("load window not armed");
    AST_PAGE_FIXED: assert property (@(posedge clk) disable iff (sys_rst)
        (s_reg.st == S_LOAD) |-> pins.addr[eeprom_host_pkg::ADDR_W-1:OFFSET_HI] == s_reg.page)
        else $error("page lines changed");
    AST_COUNT_LIMIT: assert property (@(posedge clk) disable iff (sys_rst)
        s_reg.byte_cnt <= 8'(eeprom_host_pkg::PAGE_BYTES)) else $error("page over 128 bytes");
    AST_WRITE_WE: assert property (@(posedge clk) disable iff (sys_rst)
        !pins.wr_strobe_n |-> !pins.chip_sel_n && pins.out_en_n) else $error("bad write strobe combination");
    AST_NO_WRITE_POLL: assert property (@(posedge clk) disable iff (sys_rst)
        (s_reg.st == S_POLL) |-> pins.wr_strobe_n && !pins.dq_oe) else $error("write during polling");
endmodule // eeprom_page_host

// ### verification/eeprom_model.sv
// Behavioural model of the byte-wide EEPROM on the far side of the host
`timescale 1ns/1ps
module eeprom_model
#(
    parameter int WR_CYC = 2000
)
(
    input wire logic clk,
    input wire eeprom_host_pkg::pins_s pins,
    output logic [7:0] dev_dq,
    output logic dev_oe,
    output logic rb_low
);
    localparam logic [22:0] S_AA = {15'h5555, 8'hAA};
    localparam logic [22:0] S_55 = {15'h2AAA, 8'h55};
    localparam logic [22:0] S_80 = {15'h5555, 8'h80};
    localparam logic [22:0] S_A0 = {15'h5555, 8'hA0};
    localparam logic [22:0] S_20 = {15'h5555, 8'h20};
    logic [7:0] mem [0:131071];
    logic [7:0] pend [0:127];
    logic [127:0] pend_v = '0;
    logic [9:0] page_hi = '0;
    logic [7:0] last_data = 8'h00;
    logic [16:0] lat_addr = '0;
    logic [22:0] hist [0:5];
    logic locked = 1'b0, unlocked = 1'b0, busy_q = 1'b0, loading = 1'b0, armed = 1'b0;
    int idle_cnt = 0, wr_cnt = 0;
    realtime t_fall = 0.0;

    // Array starts erased
    initial
    begin
        for (int i = 0; i < 131072; i++) mem[i] = 8'hFF;
        for (int i = 0; i < 6; i++) hist[i] = '0;
    end

    // Byte load into the page buffer, command sequences tracked
    task automatic take_byte(input logic [16:0] a, input logic [7:0] d);
        for (int i = 5; i > 0; i--) hist[i] = hist[i-1];
        hist[0] = {a[14:0], d};
        if (!locked || unlocked)
        begin
            if (pend_v == '0) page_hi = a[16:7];
            pend[a[6:0]] = d;
            pend_v[a[6:0]] = 1'b1;
            last_data = d;
        end
        if (hist[2] == S_AA && hist[1] == S_55 && hist[0] == S_A0)
        begin
            locked = 1'b1;
            unlocked = 1'b1;
            pend_v = '0;
        end
        if (hist[5] == S_AA && hist[4] == S_55 && hist[3] == S_80 && hist[2] == S_AA && hist[1] == S_55
            && hist[0] == S_20)
        begin
            locked = 1'b0;
            pend_v = '0;
        end
        idle_cnt = 0;
        loading = 1'b1;
    endtask

    // Address on the later falling edge
    always @(negedge pins.chip_sel_n or negedge pins.wr_strobe_n)
        if (!pins.chip_sel_n && !pins.wr_strobe_n)
        begin
            lat_addr = pins.addr;
            t_fall = $realtime;
            armed = 1'b1;
        end

    // Data on the earlier rising edge, short pulses dropped
    always @(posedge pins.chip_sel_n or posedge pins.wr_strobe_n)
        if (armed)
        begin
            armed = 1'b0;
            if ($realtime - t_fall > 20.0 && pins.out_en_n && pins.protect_hold_n && !busy_q)
                take_byte(lat_addr, pins.dq_out);
        end

    // Idle timer starts programming, write timer ends it
    always @(posedge clk)
        if (!pins.protect_hold_n)
        begin
            busy_q = 1'b0;
            loading = 1'b0;
            pend_v = '0;
        end
        else if (busy_q)
        begin
            wr_cnt++;
            if (wr_cnt >= WR_CYC)
            begin
                for (int i = 0; i < 128; i++)
                    if (pend_v[i]) mem[{page_hi, 7'(i)}] = pend[i];
                pend_v = '0;
                busy_q = 1'b0;
                unlocked = 1'b0;
            end
        end
        else if (loading && pins.chip_sel_n && pins.wr_strobe_n)
        begin
            idle_cnt++;
            if (idle_cnt >= eeprom_host_pkg::IDLE_CYC)
            begin
                loading = 1'b0;
                busy_q = (pend_v != '0);
                wr_cnt = 0;
            end
        end

    // Read path, busy pin and polling bit
    assign dev_oe = !pins.chip_sel_n && !pins.out_en_n && pins.wr_strobe_n && pins.protect_hold_n;
    assign dev_dq = busy_q ? {~last_data[7], last_data[6:0]} : mem[pins.addr];
    assign rb_low = busy_q || loading;
endmodule // eeprom_model

// ### verification/tb_top.sv
// Self-checking bench for the EEPROM page-write host
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic power_good = 1'b1, protect_mode = 1'b0, cancel_req = 1'b0, req_valid = 1'b0;
    eeprom_host_pkg::byte_req_s req = '0;
    eeprom_host_pkg::pins_s pins;
    logic req_ready, busy, done_pulse, timeout_pulse, dev_oe, rb_low, ready_busy_n, saw_low = 1'b0;
    logic [7:0] dq_in, dev_dq, float_q = 8'h5A;
    logic [7:0] shadow [logic [16:0]];
    logic [16:0] base;
    int n_fail = 0, n_compared = 0, n;

    always #4 clk = ~clk;
    // Released bus changes every cycle; busy pin is the inverse of the model's rb_low
    always @(posedge clk) float_q <= ~float_q;
    always @(posedge clk) if (ready_busy_n === 1'b0) saw_low <= 1'b1;
    assign dq_in = pins.dq_oe ? pins.dq_out : (dev_oe ? dev_dq : float_q);
    assign ready_busy_n = ~rb_low;

    eeprom_page_host eeprom_page_host_inst (.clk(clk), .sys_rst(sys_rst), .power_good(power_good),
        .protect_mode(protect_mode), .cancel_req(cancel_req), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .pins(pins), .dq_in(dq_in), .ready_busy_n(ready_busy_n), .busy(busy),
        .done_pulse(done_pulse), .timeout_pulse(timeout_pulse));
    eeprom_model #(.WR_CYC(2000)) eeprom_model_inst (.clk(clk), .pins(pins), .dev_dq(dev_dq),
        .dev_oe(dev_oe), .rb_low(rb_low));

    // Expected array byte: last value loaded, else erased
    function automatic logic [7:0] exp_byte(input logic [16:0] a);
        return shadow.exists(a) ? shadow[a] : 8'hFF;
    endfunction

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic summarize();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Bounded wait on a design or model flag, looked at mid-cycle
    task automatic wait_flag(input int which, input int limit);
        int i;
        for (i = 0; i < limit; i++)
        begin
            @(negedge clk);
            if (which == 0 && req_ready === 1'b1) break;
            if (which == 1 && (done_pulse === 1'b1 || timeout_pulse === 1'b1)) break;
            if (which == 2 && busy === 1'b1) break;
            if (which == 3 && eeprom_model_inst.busy_q === 1'b1) break;
        end
        if (i == limit)
        begin
            n_fail++;
            summarize();
        end
    endtask

    // One page in a scrambled offset order; keep = expect it stored
    task automatic page(input logic [16:0] b, input int cnt, input logic keep);
        logic [6:0] s0, st;
        logic [16:0] a;
        logic [7:0] d;
        @(posedge clk);
        s0 = 7'($urandom);
        st = 7'($urandom) | 7'h01;
        for (int k = 0; k < cnt; k++)
        begin
            a = {b[16:7], 7'(s0 + 7'(k) * st)};
            d = 8'($urandom_range(254, 0));
            if (keep) shadow[a] = d;
            req <= '{addr: a, data: d, last: k == cnt - 1};
            req_valid <= 1'b1;
            wait_flag(0, 2000);
            @(posedge clk);
        end
        req_valid <= 1'b0;
    endtask

    initial
    begin
        n = $urandom(77);
        repeat (8) @(posedge clk);
        check("hold_n in reset", 8'h00, 8'(pins.protect_hold_n));
        check("strobe in reset", 8'h01, 8'(pins.wr_strobe_n));
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        // Full page behind the unlock sequence
        protect_mode <= 1'b1;
        base = 17'($urandom_range(17'hFFFF, 0)) & 17'h1FF80;
        page(base, 128, 1'b1);
        wait_flag(1, 40000);
        check("done after page", 8'h01, 8'(done_pulse));
        check("no timeout", 8'h00, 8'(timeout_pulse));
        check("busy pin seen low", 8'h01, 8'(saw_low));
        check("protected", 8'h01, 8'(eeprom_model_inst.locked));
        // Cancel of software protection
        @(posedge clk);
        protect_mode <= 1'b0;
        cancel_req <= 1'b1;
        wait_flag(2, 100);
        @(posedge clk);
        cancel_req <= 1'b0;
        wait_flag(1, 40000);
        check("done after cancel", 8'h01, 8'(done_pulse));
        check("unprotected", 8'h00, 8'(eeprom_model_inst.locked));
        check("cell 5555", exp_byte(17'h05555), eeprom_model_inst.mem[17'h05555]);
        check("cell 2AAA", exp_byte(17'h02AAA), eeprom_model_inst.mem[17'h02AAA]);
        // Single-byte page at a random place
        base = 17'($urandom_range(17'hFFFF, 0));
        page(base, 1, 1'b1);
        wait_flag(1, 40000);
        check("done one byte", 8'h01, 8'(done_pulse));
        // Power loss while the last page programs
        page(17'h1FF80, 128, 1'b0);
        wait_flag(3, 20000);
        @(posedge clk);
        power_good <= 1'b0;
        repeat (2) @(posedge clk);
        check("hold_n on power loss", 8'h00, 8'(pins.protect_hold_n));
        repeat (4) @(posedge clk);
        check("idle after abort", 8'h00, 8'(busy));
        power_good <= 1'b1;
        repeat (4) @(posedge clk);
        for (int k = 0; k < 128; k++)
            check("aborted cell", 8'hFF, eeprom_model_inst.mem[{10'h3FF, 7'(k)}]);
        foreach (shadow[a])
            check("stored cell", exp_byte(a), eeprom_model_inst.mem[a]);
        summarize();
    end
endmodule // tb_top
